/* File: common/pmic_cfg_pkg.sv */
package pmic_cfg_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] OFF_REG11_CTRL = 8'h30;
  localparam logic [7:0] OFF_HAPTIC = 8'h31;
  localparam logic [7:0] OFF_RAMP_A = 8'h32;
  localparam logic [7:0] OFF_RAMP_B = 8'h33;
  localparam logic [7:0] OFF_CONV_MAN = 8'h34;
  localparam logic [7:0] OFF_CONV_CFG = 8'h35;
  localparam logic [7:0] OFF_SUPPLY_WARN = 8'h36;
  localparam logic [7:0] OFF_RES_LO = 8'h37;
  localparam logic [7:0] OFF_RES_HI = 8'h38;
  localparam logic [7:0] RESET_VAL = 8'h00;
  localparam logic [7:0] RAMP_B_MASK = 8'h81;
  localparam logic [7:0] HAPTIC_MASK = 8'h3f;
  localparam logic [7:0] CONV_MAN_MASK = 8'h3f;
  localparam logic [5:0] HAPTIC_BRAKE = 6'h00;
  localparam int MAN_GO_BIT = 4;
  localparam int INTERVAL_BIT = 5;
  localparam logic [3:0] CH_MAX = 4'ha;
  localparam logic [3:0] CH_RSV0 = 4'h6;
  localparam logic [3:0] CH_RSV1 = 4'h7;
  localparam int RES_W = 10;
  localparam int CLK_MHZ = 250;
  localparam int ECO_PERIOD_US = 10000;
  localparam int FAST_PERIOD_US = 1000;
  localparam int ECO_CYCLES = ECO_PERIOD_US * CLK_MHZ;
  localparam int FAST_CYCLES = FAST_PERIOD_US * CLK_MHZ;

  typedef enum logic [1:0] {
    PIN_NONE = 2'b00,
    PIN_ONE = 2'b01,
    PIN_TWO = 2'b10,
    PIN_THIRTEEN = 2'b11
  } pin_src_e;

  typedef struct packed {
    logic seq_target;
    pin_src_e pin_voltage_src;
    logic voltage_choice;
    logic pulldown_off;
    pin_src_e pin_enable_src;
    logic on;
  } reg11_ctrl_s;

  typedef struct packed {
    logic in2_comparator_on;
    logic in3_current_src_on;
    logic in2_current_src_on;
    logic in1_current_src_on;
    logic in3_auto_measure_on;
    logic in2_auto_measure_on;
    logic in1_auto_measure_on;
    logic supply_auto_measure_on;
  } conv_cfg_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } bus_req_s;
endpackage

/* File: rtl/pin_edge.sv */
`timescale 1ns/1ns
module pin_edge (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [2:0] pins_i,
  input wire pmic_cfg_pkg::pin_src_e sel_i,
  output logic rise_o,
  output logic fall_o
);
  logic level;
  logic prev_q;
  always_comb
  begin
    case (sel_i)
      pmic_cfg_pkg::PIN_ONE: level = pins_i[0];
      pmic_cfg_pkg::PIN_TWO: level = pins_i[1];
      pmic_cfg_pkg::PIN_THIRTEEN: level = pins_i[2];
      default: level = 1'b0;
    endcase
  end
  // Track selected level, so a select change can read as an edge
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      prev_q <= 1'b0;
    else
      prev_q <= level;
  end
  assign rise_o = (sel_i != pmic_cfg_pkg::PIN_NONE) && level && !prev_q;
  assign fall_o = (sel_i != pmic_cfg_pkg::PIN_NONE) && !level && prev_q;
endmodule // pin_edge

/* File: rtl/regulator_and_adc_config_regs.sv */
// Overview of operation
// - Bit7 sequencer target, bit0 regulator enable
// - Bits6:5 pick voltage-choice pin source
// - Pin rise selects A, fall selects B
// - Bit4 picks level A or B
// - Bit3 set removes disabled-state pull-down
// - Bits2:1 pick pin that toggles enable
// - Haptic code zero means braked off
// - Nonzero haptic code sets linear drive
// - First ramp register holds eight choices
// - Second ramp: bits 7,0; rest reserved
// - Interval bit: 10 ms or 1 ms
// - Start bit self-clears when conversion completes
// - Manual channel codes; reserved codes flagged
// - Bit7 enables input-2 comparator
// - Bits6:4 enable input current sources
// - Bits3:1 enable input auto measurements
// - Bit0 supply auto measure, else idle-gated
// - Eight-bit supply warning threshold
// - Result low bits 7:6, high byte next
`timescale 1ns/1ns
module regulator_and_adc_config_regs #(
  parameter int ECO_CYCLES = pmic_cfg_pkg::ECO_CYCLES,
  parameter int FAST_CYCLES = pmic_cfg_pkg::FAST_CYCLES
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [pmic_cfg_pkg::ADDR_W-1:0] addr_i,
  input wire logic [pmic_cfg_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [pmic_cfg_pkg::DATA_W-1:0] rdata_o,
  input wire logic [2:0] general_pins_i,
  input wire logic seq_enable_i,
  input wire logic seq_apply_i,
  input wire logic charger_or_motor_on_i,
  input wire logic conv_done_i,
  input wire logic [pmic_cfg_pkg::RES_W-1:0] conv_result_i,
  output logic reg11_on_o,
  output logic reg11_voltage_b_o,
  output logic reg11_pulldown_on_o,
  output logic [5:0] haptic_level_o,
  output logic haptic_brake_o,
  output logic [7:0] ramp_choice_a_o,
  output logic [1:0] ramp_choice_b_o,
  output logic conv_start_o,
  output logic [3:0] manual_channel_sel_o,
  output logic manual_channel_bad_o,
  output logic auto_seq_tick_o,
  output logic [7:0] conv_cfg_o,
  output logic supply_auto_active_o,
  output logic [7:0] supply_warn_level_o
);
  pmic_cfg_pkg::bus_req_s req;
  pmic_cfg_pkg::reg11_ctrl_s reg11_q;
  pmic_cfg_pkg::conv_cfg_s cfg_q;
  logic [7:0] haptic_q;
  logic [7:0] ramp_a_q;
  logic [7:0] ramp_b_q;
  logic [7:0] man_q;
  logic [7:0] warn_q;
  logic [pmic_cfg_pkg::RES_W-1:0] result_q;
  logic [7:0] rdata_d;
  logic en_rise;
  logic en_fall;
  logic v_rise;
  logic v_fall;
  logic [31:0] tick_cnt_q;
  logic [31:0] tick_limit;
  logic wr_r11;
  logic wr_man;

  assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
  assign wr_r11 = req.wr && (req.addr == pmic_cfg_pkg::OFF_REG11_CTRL);
  assign wr_man = req.wr && (req.addr == pmic_cfg_pkg::OFF_CONV_MAN);

  pin_edge u_enable_pin (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .pins_i(general_pins_i),
    .sel_i(reg11_q.pin_enable_src),
    .rise_o(en_rise),
    .fall_o(en_fall)
  );

  pin_edge u_voltage_pin (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .pins_i(general_pins_i),
    .sel_i(reg11_q.pin_voltage_src),
    .rise_o(v_rise),
    .fall_o(v_fall)
  );

  // Hardware pin events win over a same-cycle software write
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      reg11_q <= pmic_cfg_pkg::reg11_ctrl_s'(pmic_cfg_pkg::RESET_VAL);
    else
    begin
      if (wr_r11)
        reg11_q <= pmic_cfg_pkg::reg11_ctrl_s'(req.wdata);
      if (seq_apply_i)
        reg11_q.seq_target <= seq_enable_i;
      if (seq_apply_i && reg11_q.pin_enable_src == pmic_cfg_pkg::PIN_NONE)
        reg11_q.on <= seq_enable_i;
      if (en_rise)
        reg11_q.on <= 1'b1;
      else if (en_fall)
        reg11_q.on <= 1'b0;
      if (v_rise)
        reg11_q.voltage_choice <= 1'b0;
      else if (v_fall)
        reg11_q.voltage_choice <= 1'b1;
    end
  end

  // Reserved bits masked on the way in, so reads need no gating
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      haptic_q <= pmic_cfg_pkg::RESET_VAL;
    else if (req.wr && req.addr == pmic_cfg_pkg::OFF_HAPTIC)
      haptic_q <= req.wdata & pmic_cfg_pkg::HAPTIC_MASK;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      ramp_a_q <= pmic_cfg_pkg::RESET_VAL;
    else if (req.wr && req.addr == pmic_cfg_pkg::OFF_RAMP_A)
      ramp_a_q <= req.wdata;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      ramp_b_q <= pmic_cfg_pkg::RESET_VAL;
    else if (req.wr && req.addr == pmic_cfg_pkg::OFF_RAMP_B)
      ramp_b_q <= req.wdata & pmic_cfg_pkg::RAMP_B_MASK;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      cfg_q <= pmic_cfg_pkg::conv_cfg_s'(pmic_cfg_pkg::RESET_VAL);
    else if (req.wr && req.addr == pmic_cfg_pkg::OFF_CONV_CFG)
      cfg_q <= pmic_cfg_pkg::conv_cfg_s'(req.wdata);
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      warn_q <= pmic_cfg_pkg::RESET_VAL;
    else if (req.wr && req.addr == pmic_cfg_pkg::OFF_SUPPLY_WARN)
      warn_q <= req.wdata;
  end

  // Completion beats a same-cycle rewrite of the start bit; other
  // fields still take the write
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      man_q <= pmic_cfg_pkg::RESET_VAL;
    else
    begin
      if (wr_man)
        man_q <= req.wdata & pmic_cfg_pkg::CONV_MAN_MASK;
      if (conv_done_i && man_q[pmic_cfg_pkg::MAN_GO_BIT])
        man_q[pmic_cfg_pkg::MAN_GO_BIT] <= 1'b0;
    end
  end

  // Result latched only for a conversion that software requested
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      result_q <= '0;
    else if (conv_done_i && man_q[pmic_cfg_pkg::MAN_GO_BIT])
      result_q <= conv_result_i;
  end

  assign tick_limit = man_q[pmic_cfg_pkg::INTERVAL_BIT] ?
    32'(FAST_CYCLES) : 32'(ECO_CYCLES);

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      tick_cnt_q <= '0;
      auto_seq_tick_o <= 1'b0;
    end
    else if (tick_cnt_q >= tick_limit - 32'd1)
    begin
      tick_cnt_q <= '0;
      auto_seq_tick_o <= 1'b1;
    end
    else
    begin
      tick_cnt_q <= tick_cnt_q + 32'd1;
      auto_seq_tick_o <= 1'b0;
    end
  end

  always_comb
  begin
    case (req.addr)
      pmic_cfg_pkg::OFF_REG11_CTRL: rdata_d = 8'(reg11_q);
      pmic_cfg_pkg::OFF_HAPTIC: rdata_d = haptic_q;
      pmic_cfg_pkg::OFF_RAMP_A: rdata_d = ramp_a_q;
      pmic_cfg_pkg::OFF_RAMP_B: rdata_d = ramp_b_q;
      pmic_cfg_pkg::OFF_CONV_MAN: rdata_d = man_q;
      pmic_cfg_pkg::OFF_CONV_CFG: rdata_d = 8'(cfg_q);
      pmic_cfg_pkg::OFF_SUPPLY_WARN: rdata_d = warn_q;
      pmic_cfg_pkg::OFF_RES_LO: rdata_d = {result_q[1:0], 6'h00};
      pmic_cfg_pkg::OFF_RES_HI: rdata_d = result_q[9:2];
      default: rdata_d = 8'h00;
    endcase
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      rdata_o <= 8'h00;
    else if (req.rd)
      rdata_o <= rdata_d;
    else
      rdata_o <= 8'h00;
  end

  // Outputs lag register state by one cycle; all straight from flops
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      reg11_on_o <= 1'b0;
    else
      reg11_on_o <= reg11_q.on;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      reg11_voltage_b_o <= 1'b0;
    else
      reg11_voltage_b_o <= reg11_q.voltage_choice;
  end

  // Pull-down only ever acts while the regulator is off
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      reg11_pulldown_on_o <= 1'b1;
    else
      reg11_pulldown_on_o <= !reg11_q.on && !reg11_q.pulldown_off;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      haptic_level_o <= '0;
    else
      haptic_level_o <= haptic_q[5:0];
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      haptic_brake_o <= 1'b1;
    else
      haptic_brake_o <= haptic_q[5:0] == pmic_cfg_pkg::HAPTIC_BRAKE;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      ramp_choice_a_o <= '0;
    else
      ramp_choice_a_o <= ramp_a_q;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      ramp_choice_b_o <= '0;
    else
      ramp_choice_b_o <= {ramp_b_q[7], ramp_b_q[0]};
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      conv_start_o <= 1'b0;
    else
      conv_start_o <= man_q[pmic_cfg_pkg::MAN_GO_BIT];
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      manual_channel_sel_o <= '0;
    else
      manual_channel_sel_o <= man_q[3:0];
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      manual_channel_bad_o <= 1'b0;
    else
      manual_channel_bad_o <= (man_q[3:0] > pmic_cfg_pkg::CH_MAX) ||
        (man_q[3:0] == pmic_cfg_pkg::CH_RSV0) ||
        (man_q[3:0] == pmic_cfg_pkg::CH_RSV1);
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      conv_cfg_o <= '0;
    else
      conv_cfg_o <= 8'(cfg_q);
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      supply_auto_active_o <= 1'b0;
    else
      supply_auto_active_o <= cfg_q.supply_auto_measure_on ||
        charger_or_motor_on_i;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      supply_warn_level_o <= '0;
    else
      supply_warn_level_o <= warn_q;
  end
endmodule // regulator_and_adc_config_regs

/* File: bench/regulator_and_adc_config_regs_properties.sv */
`timescale 1ns/1ns
module regulator_and_adc_config_regs_checker #(
  parameter int ECO_CYCLES = 20,
  parameter int FAST_CYCLES = 5
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic seq_apply_i,
  input wire logic [2:0] general_pins_i,
  input wire logic conv_done_i,
  input wire logic [7:0] rdata_o,
  input wire logic reg11_pulldown_on_o,
  input wire logic [5:0] haptic_level_o,
  input wire logic haptic_brake_o,
  input wire logic [1:0] ramp_choice_b_o,
  input wire logic conv_start_o,
  input wire logic [3:0] manual_channel_sel_o,
  input wire logic manual_channel_bad_o,
  input wire logic auto_seq_tick_o,
  input wire logic [7:0] conv_cfg_o,
  input wire logic supply_auto_active_o,
  input wire logic [7:0] supply_warn_level_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // Pins quiet and sequencer idle, so nothing can mask the write
  sequence s_w30;
    general_pins_i == 3'h0 ##1 wr_i && addr_i == 8'h30 &&
      wdata_i[6:5] == 2'h0 && wdata_i[2:1] == 2'h0 && !seq_apply_i &&
      general_pins_i == 3'h0;
  endsequence
  sequence s_done;
    conv_done_i ##1 !(wr_i && addr_i == 8'h34);
  endsequence
  a_read_idle_zero: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data not zero outside a read");
  a_warn_read_match: assert property (rd_i && addr_i == 8'h36 |=>
    rdata_o == supply_warn_level_o) else $error("threshold readback differs");
  a_warn_follows_write: assert property (wr_i && addr_i == 8'h36 |=>
    ##1 supply_warn_level_o == $past(wdata_i, 2))
    else $error("threshold output not the written value");
  a_brake_on_zero: assert property (haptic_brake_o ==
    (haptic_level_o == 6'h00)) else $error("brake state wrong for code");
  a_pulldown_after_write: assert property (s_w30 |=> ##1
    reg11_pulldown_on_o == !($past(wdata_i[0], 2) || $past(wdata_i[3], 2)))
    else $error("pull-down state wrong");
  a_ramp_b_bits: assert property (wr_i && addr_i == 8'h33 |->
    ##2 ramp_choice_b_o == {$past(wdata_i[7], 2), $past(wdata_i[0], 2)})
    else $error("second ramp choices wrong");
  a_start_self_clear: assert property (s_done |=> !conv_start_o)
    else $error("start bit not cleared after completion");
  a_tick_spacing: assert property (auto_seq_tick_o |=>
    !auto_seq_tick_o [*4]) else $error("sequence ticks too close");
  a_channel_flag: assert property (manual_channel_bad_o ==
    (manual_channel_sel_o inside {4'h6, 4'h7} || manual_channel_sel_o > 4'ha))
    else $error("reserved channel flag wrong");
  a_supply_auto: assert property (conv_cfg_o[0] |->
    supply_auto_active_o) else $error("supply auto measure not active");
endmodule // regulator_and_adc_config_regs_checker

bind regulator_and_adc_config_regs regulator_and_adc_config_regs_checker #(
  .ECO_CYCLES(ECO_CYCLES), .FAST_CYCLES(FAST_CYCLES)) u_chk (.core_clk_i,
  .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .seq_apply_i, .conv_done_i,
  .general_pins_i, .rdata_o, .reg11_pulldown_on_o, .haptic_level_o,
  .haptic_brake_o, .ramp_choice_b_o, .conv_start_o, .manual_channel_sel_o,
  .manual_channel_bad_o, .auto_seq_tick_o, .conv_cfg_o,
  .supply_auto_active_o, .supply_warn_level_o);

/* File: bench/test_regulator_and_adc_config_regs.sv */
`timescale 1ns/1ns
module test_regulator_and_adc_config_regs;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, n, k;
  logic wr_i = 1'b0, rd_i = 1'b0, seq_enable_i = 1'b0, seq_apply_i = 1'b0;
  logic charger_or_motor_on_i = 1'b0, conv_done_i = 1'b0;
  logic [2:0] general_pins_i = 3'h0;
  logic [9:0] conv_result_i = 10'h000;
  logic [7:0] rdata_o, ramp_choice_a_o, conv_cfg_o, supply_warn_level_o;
  logic reg11_on_o, reg11_voltage_b_o, reg11_pulldown_on_o, haptic_brake_o;
  logic conv_start_o, manual_channel_bad_o, auto_seq_tick_o;
  logic supply_auto_active_o;
  logic [5:0] haptic_level_o;
  logic [1:0] ramp_choice_b_o;
  logic [3:0] manual_channel_sel_o;
  int failures = 0, total_checks = 0;
  logic [7:0] msk [7] = '{8'hff, 8'h3f, 8'hff, 8'h81, 8'h3f, 8'hff, 8'hff};
  // Short interval counts keep the tick test brief
  regulator_and_adc_config_regs #(.ECO_CYCLES(20), .FAST_CYCLES(5)) dut (
    .core_clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .general_pins_i, .seq_enable_i, .seq_apply_i, .charger_or_motor_on_i,
    .conv_done_i, .conv_result_i, .reg11_on_o, .reg11_voltage_b_o,
    .reg11_pulldown_on_o, .haptic_level_o, .haptic_brake_o, .ramp_choice_a_o,
    .ramp_choice_b_o, .conv_start_o, .manual_channel_sel_o,
    .manual_channel_bad_o, .auto_seq_tick_o, .conv_cfg_o,
    .supply_auto_active_o, .supply_warn_level_o);
  initial
  begin
    forever #2 core_clk_i = ~core_clk_i;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // Each access starts on a fresh edge, so strobes never toggle twice
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    @(negedge core_clk_i);
    check(rdata_o, exp);
  endtask
  task automatic out;
    @(posedge core_clk_i);
    @(negedge core_clk_i);
  endtask
  task automatic wait_tick(output logic [7:0] c);
    c = 8'h00;
    do
    begin
      @(negedge core_clk_i);
      c++;
    end
    while (auto_seq_tick_o !== 1'b1 && c < 8'd60);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d, mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    #40000;
    failures++;
    tally_and_finish;
  end
  initial
  begin
    repeat (5) @(posedge core_clk_i);
    rst_i <= 1'b0;
    for (n = 0; n < 9; n++) rchk(8'h30 + n, 8'h00);
    check(haptic_brake_o, 1'b1);
    check(reg11_pulldown_on_o, 1'b1);
    for (n = 0; n < 7; n++) wr(8'h30 + n, 8'hff);
    wr(8'h37, 8'hff);
    wr(8'h50, 8'hff);
    for (n = 0; n < 7; n++) rchk(8'h30 + n, msk[n]);
    rchk(8'h37, 8'h00);
    rchk(8'h50, 8'h00);
    check(ramp_choice_a_o, 8'hff);
    check(ramp_choice_b_o, 2'h3);
    check(conv_cfg_o, 8'hff);
    check(supply_warn_level_o, 8'hff);
    check(haptic_brake_o, 1'b0);
    check(haptic_level_o, 8'h3f);
    check(supply_auto_active_o, 1'b1);
    check(conv_start_o, 1'b1);
    $display("register access test done");
    @(posedge core_clk_i);
    conv_result_i <= 10'h2d5;
    conv_done_i <= 1'b1;
    @(posedge core_clk_i);
    conv_done_i <= 1'b0;
    rchk(8'h34, 8'h2f);
    check(conv_start_o, 1'b0);
    rchk(8'h37, 8'h40);
    rchk(8'h38, 8'hb5);
    // Completion with the start bit clear must leave the result alone
    @(posedge core_clk_i);
    conv_result_i <= 10'h0aa;
    conv_done_i <= 1'b1;
    @(posedge core_clk_i);
    conv_done_i <= 1'b0;
    rchk(8'h38, 8'hb5);
    for (n = 0; n < 16; n++)
    begin
      wr(8'h34, n);
      out;
      check(manual_channel_bad_o, n == 6 || n == 7 || n > 10);
      check(manual_channel_sel_o, n);
    end
    for (n = 0; n < 2; n++)
    begin
      wr(8'h34, n ? 8'h20 : 8'h00);
      wait_tick(k);
      wait_tick(k);
      check(k, n ? 8'd5 : 8'd20);
    end
    $display("converter test done");
    wr(8'h30, 8'h52);
    @(posedge core_clk_i);
    general_pins_i <= 3'h3;
    for (k = 0; k < 8 && reg11_on_o !== 1'b1; k++) @(posedge core_clk_i);
    rchk(8'h30, 8'h43);
    check(reg11_pulldown_on_o, 1'b0);
    @(posedge core_clk_i);
    general_pins_i <= 3'h0;
    for (k = 0; k < 8 && reg11_on_o !== 1'b0; k++) @(posedge core_clk_i);
    rchk(8'h30, 8'h52);
    check({reg11_voltage_b_o, reg11_pulldown_on_o}, 2'h3);
    wr(8'h30, 8'h08);
    seq_enable_i <= 1'b1;
    @(posedge core_clk_i);
    seq_apply_i <= 1'b1;
    @(posedge core_clk_i);
    seq_apply_i <= 1'b0;
    rchk(8'h30, 8'h89);
    check({reg11_on_o, reg11_pulldown_on_o}, 2'h2);
    wr(8'h30, 8'h10);
    out;
    check(reg11_voltage_b_o, 1'b1);
    wr(8'h30, 8'h66);
    general_pins_i <= 3'h4;
    repeat (3) @(posedge core_clk_i);
    rchk(8'h30, 8'h67);
    @(posedge core_clk_i);
    general_pins_i <= 3'h0;
    repeat (3) @(posedge core_clk_i);
    rchk(8'h30, 8'h76);
    $display("regulator test done");
    wr(8'h35, 8'h00);
    charger_or_motor_on_i <= 1'b1;
    out;
    check(supply_auto_active_o, 1'b1);
    @(posedge core_clk_i);
    charger_or_motor_on_i <= 1'b0;
    wr(8'h31, 8'h00);
    out;
    check({haptic_brake_o, supply_auto_active_o}, 2'h2);
    $display("monitor test done");
    tally_and_finish;
  end
endmodule // test_regulator_and_adc_config_regs
